// ### amute_cfg.svh
/*
 register offsets, field positions, reset values and hold-time sample counts
 of the auto-mute and output-stage configuration block.
 assumes inclusion by bare name from the design and checker files.
*/
`ifndef AMUTE_CFG_SVH
`define AMUTE_CFG_SVH

`define OFS_SILENCE_CTRL    8'h50
`define OFS_HOLD_TIME       8'h51
`define OFS_STAGE_CTRL      8'h53
`define OFS_LEVEL_TRIM      8'h54

`define RST_SILENCE_CTRL    8'h07
`define RST_HOLD_TIME       8'h00
`define RST_STAGE_CTRL      8'h00
`define RST_LEVEL_TRIM      8'h00

`define BIT_MUTE_EN_LEFT    0
`define BIT_MUTE_EN_RIGHT   1
`define BIT_MUTE_JOINT      2
`define POS_HOLD_LEFT       4
`define POS_HOLD_RIGHT      0
`define POS_BANDWIDTH       5
`define BIT_PHASE_SAME      0
`define POS_LEVEL_TRIM      0

// hold times in microseconds at the reference rate, counts in samples
`define REF_RATE_HZ         96000
`define HOLD_US_0           11500
`define HOLD_US_1           53000
`define HOLD_US_2           106500
`define HOLD_US_3           266500
`define HOLD_US_4           535000
`define HOLD_US_5           1065000
`define HOLD_US_6           2665000
`define HOLD_US_7           5330000
`define HOLD_SAMPLES(us)    ((64'(us) * `REF_RATE_HZ) / 1000000)

`endif

// ### amute_pkg.sv
/*
 types shared by the auto-mute configuration block.
 assumes amute_cfg.svh for all numeric constants.
*/
package amute_pkg;
   typedef enum logic [1:0] {
      bw_100k,
      bw_80k,
      bw_120k,
      bw_175k
   } bandwidth_t;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      bandwidth_t bandwidth;
      logic       phase_same;
      logic [4:0] level_trim;
   } stage_cfg_t;

   typedef enum logic {
      ch_live,
      ch_muted
   } mute_state_t;
endpackage : amute_pkg

// ### auto_mute_output_config.sv
/*
 auto-mute and output-stage configuration registers with per-channel
 zero-run detection and mute decision.
 assumes a byte-wide host register port synchronous to clk, and one
 sample strobe per sample period carrying both channels.
*/
// Contract
// R1 - bit 0 of the auto-silence control register enables left auto mute.
// R2 - bit 1 of the auto-silence control register enables right auto mute.
// R3 - bit 2 clear mutes channels independently, set mutes both only when both qualify.
// R4 - left zero samples are counted and left mute is allowed once the left hold length is reached.
// R5 - right zero samples are counted and right mute is allowed once the right hold length is reached.
// R6 - hold codes pick 11.5 ms up to 5.33 s at 96 kHz as fixed sample counts.
// R7 - the two-bit bandwidth field picks 100, 80, 120 or 175 kHz.
// R8 - software picks 175 kHz bandwidth when switching at 768 kHz.
// R9 - the phase bit drives left and right PWM out of phase when clear, in phase when set.
// R10 - the five-bit trim field attenuates 0.5 dB per step, 0 dB to -15.5 dB.
// R11 - any nonzero sample restarts the run and releases a muted channel at once.
// R12 - reserved bits store and read back but steer nothing.
`timescale 1ns/100ps
`include "amute_cfg.svh"
module auto_mute_output_config #(
   parameter int SAMPLE_W = 24,
   parameter int CNT_W    = 20
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ce,
   input  wire amute_pkg::reg_req_t    reg_req,
   output logic [7:0]                  reg_rdata,
   output logic                        reg_ack,
   input  wire logic                   sample_valid,
   input  wire logic [SAMPLE_W-1:0]    sample_left,
   input  wire logic [SAMPLE_W-1:0]    sample_right,
   output logic                        mute_left,
   output logic                        mute_right,
   output amute_pkg::stage_cfg_t       stage_cfg
);
   logic [7:0] silence_ctrl_ff;
   logic [7:0] hold_time_ff;
   logic [7:0] stage_ctrl_ff;
   logic [7:0] level_trim_ff;
   logic [7:0] rdata_ff;
   logic       ack_ff;
   logic       mute_left_ff;
   logic       mute_right_ff;
   logic       hold_met_left;
   logic       hold_met_right;

   wire logic wr_go   = reg_req.en && reg_req.wr;
   wire logic hit_ctl = (reg_req.addr == `OFS_SILENCE_CTRL);
   wire logic hit_hld = (reg_req.addr == `OFS_HOLD_TIME);
   wire logic hit_stg = (reg_req.addr == `OFS_STAGE_CTRL);
   wire logic hit_trm = (reg_req.addr == `OFS_LEVEL_TRIM);

   // unmapped addresses read zero and ignore writes
   wire logic [7:0] nxt_rdata = hit_ctl ? silence_ctrl_ff :
                                hit_hld ? hold_time_ff :
                                hit_stg ? stage_ctrl_ff :
                                hit_trm ? level_trim_ff : 8'h00;

   // full bytes are stored so reserved bits read back
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         silence_ctrl_ff <= `RST_SILENCE_CTRL;
         hold_time_ff    <= `RST_HOLD_TIME;
         stage_ctrl_ff   <= `RST_STAGE_CTRL;
         level_trim_ff   <= `RST_LEVEL_TRIM;
      end else if (ce && wr_go) begin
         if (hit_ctl) silence_ctrl_ff <= reg_req.wdata; // R12
         if (hit_hld) hold_time_ff    <= reg_req.wdata; // R12
         if (hit_stg) stage_ctrl_ff   <= reg_req.wdata; // R12
         if (hit_trm) level_trim_ff   <= reg_req.wdata; // R12
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
         ack_ff   <= 1'b0;
      end else if (ce) begin
         ack_ff <= reg_req.en;
         if (reg_req.en && !reg_req.wr) rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_ack   = ack_ff;

   wire logic [2:0] hold_left  = hold_time_ff[`POS_HOLD_LEFT +: 3];
   wire logic [2:0] hold_right = hold_time_ff[`POS_HOLD_RIGHT +: 3];

   zero_run_detect #(
      .CNT_W (CNT_W)
   ) u_left (
      .clk          (clk),
      .rst_n        (rst_n),
      .ce           (ce),
      .sample_valid (sample_valid),
      .sample_zero  (sample_left == '0),
      .hold_sel     (hold_left), // R4 R6
      .hold_met     (hold_met_left)
   );

   zero_run_detect #(
      .CNT_W (CNT_W)
   ) u_right (
      .clk          (clk),
      .rst_n        (rst_n),
      .ce           (ce),
      .sample_valid (sample_valid),
      .sample_zero  (sample_right == '0),
      .hold_sel     (hold_right), // R5 R6
      .hold_met     (hold_met_right)
   );

   wire logic en_left   = silence_ctrl_ff[`BIT_MUTE_EN_LEFT];  // R1
   wire logic en_right  = silence_ctrl_ff[`BIT_MUTE_EN_RIGHT]; // R2
   wire logic joint     = silence_ctrl_ff[`BIT_MUTE_JOINT];
   wire logic cond_left  = en_left && hold_met_left;
   wire logic cond_right = en_right && hold_met_right;
   // joint mode waits for both; a disabled channel never qualifies
   wire logic both       = cond_left && cond_right;
   wire logic nxt_mute_left  = joint ? both : cond_left;  // R3
   wire logic nxt_mute_right = joint ? both : cond_right; // R3

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mute_left_ff  <= 1'b0;
         mute_right_ff <= 1'b0;
      end else if (ce) begin
         mute_left_ff  <= nxt_mute_left;
         mute_right_ff <= nxt_mute_right;
      end
   end

   assign mute_left  = mute_left_ff;
   assign mute_right = mute_right_ff;

   // drawn straight from register flops; the analog stage decodes dB and kHz
   assign stage_cfg.bandwidth  = amute_pkg::bandwidth_t'(stage_ctrl_ff[`POS_BANDWIDTH +: 2]); // R7
   assign stage_cfg.phase_same = stage_ctrl_ff[`BIT_PHASE_SAME]; // R9
   assign stage_cfg.level_trim = level_trim_ff[`POS_LEVEL_TRIM +: 5]; // R10
endmodule : auto_mute_output_config

// ### auto_mute_output_config_bench.sv
/*
 self-checking bench: register accesses and zero-sample streams.
 assumes the package, header and checker are compiled first.
*/
`timescale 1ns/100ps
module auto_mute_output_config_bench;
   logic                  clk, rst_n, ce, sample_valid, reg_ack, mute_left, mute_right;
   logic [7:0]            reg_rdata;
   logic [23:0]           sample_left, sample_right;
   amute_pkg::reg_req_t   reg_req;
   amute_pkg::stage_cfg_t stage_cfg;
   int                    err_total = 0, compares = 0;
   auto_mute_output_config i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .sample_valid(sample_valid),
      .sample_left(sample_left), .sample_right(sample_right), .mute_left(mute_left),
      .mute_right(mute_right), .stage_cfg(stage_cfg));
   task report_and_stop;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   task chk(string n, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task acc(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_req <= '{1'b1, a, w, d};
      @(posedge clk);
      reg_req.en <= 1'b0;
      #1 chk("ack", 8'h01, {7'h0, reg_ack});
   endtask : acc
   task wr(logic [7:0] a, logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task rd(logic [7:0] a, logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk("rdata", e, reg_rdata);
   endtask : rd
   // sample data held between strobes, as a real serial input would
   task send(int n, logic [23:0] l, logic [23:0] r);
      repeat (n) begin
         @(posedge clk);
         sample_valid <= 1'b1;
         sample_left  <= l;
         sample_right <= r;
         @(posedge clk);
         sample_valid <= 1'b0;
      end
      repeat (3) @(posedge clk);
   endtask : send
   task mt(logic el, logic er);
      repeat (2) @(posedge clk);
      #1 chk("mute", {6'h0, el, er}, {6'h0, mute_left, mute_right});
   endtask : mt
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #500000;
      err_total++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      sample_valid = 1'b0;
      sample_left = 24'h0;
      sample_right = 24'h0;
      reg_req = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h50, 8'h07);
      rd(8'h51, 8'h00);
      rd(8'h53, 8'h00);
      rd(8'h54, 8'h00);
      rd(8'h52, 8'h00);
      wr(8'h52, 8'hff);
      rd(8'h52, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(8'h53, {1'b1, i[1:0], 4'hf, i[0]});
         chk("stage", {i[1:0], i[0], 5'h00}, stage_cfg);
      end
      rd(8'h53, 8'hff);
      wr(8'h54, 8'he5);
      chk("stage", 8'he5, stage_cfg);
      wr(8'h54, 8'h1f);
      rd(8'h54, 8'h1f);
      // request offered while frozen must be dropped
      @(posedge clk);
      ce <= 1'b0;
      reg_req <= '{1'b1, 8'h54, 1'b1, 8'h00};
      repeat (3) @(posedge clk);
      reg_req.en <= 1'b0;
      ce <= 1'b1;
      #1 chk("stage", 8'hff, stage_cfg);
      wr(8'h50, 8'h03);
      send(1103, 24'h0, 24'h0);
      mt(1'b0, 1'b0);
      send(1, 24'h0, 24'h0);
      mt(1'b1, 1'b1);
      send(1, 24'h1, 24'h0);
      mt(1'b0, 1'b1);
      wr(8'h51, 8'h10);
      send(1, 24'h1, 24'h800000);
      send(1104, 24'h0, 24'h0);
      mt(1'b0, 1'b1);
      send(3983, 24'h0, 24'h0);
      mt(1'b0, 1'b1);
      send(1, 24'h0, 24'h0);
      mt(1'b1, 1'b1);
      wr(8'h51, 8'h01);
      wr(8'h50, 8'h07);
      send(1, 24'h1, 24'h1);
      send(5087, 24'h0, 24'h0);
      mt(1'b0, 1'b0);
      send(1, 24'h0, 24'h0);
      mt(1'b1, 1'b1);
      wr(8'h50, 8'h06);
      mt(1'b0, 1'b0);
      wr(8'h50, 8'h02);
      mt(1'b0, 1'b1);
      wr(8'h50, 8'h01);
      mt(1'b1, 1'b0);
      // third hold code on the right, left stays muted meanwhile
      wr(8'h50, 8'h03);
      wr(8'h51, 8'h02);
      send(1, 24'h0, 24'h1);
      send(10223, 24'h0, 24'h0);
      mt(1'b1, 1'b0);
      send(1, 24'h0, 24'h0);
      mt(1'b1, 1'b1);
      report_and_stop();
   end
endmodule : auto_mute_output_config_bench

// ### mute_chk.sv
/*
 assertions on the auto-mute configuration block's ports.
 assumes bind to auto_mute_output_config; ce high while in reset.
*/
`timescale 1ns/100ps
`include "amute_cfg.svh"
module mute_chk #(
   parameter int SAMPLE_W = 24,
   parameter int CNT_W    = 20
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  ce,
   input wire amute_pkg::reg_req_t   reg_req,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  reg_ack,
   input wire logic                  sample_valid,
   input wire logic [SAMPLE_W-1:0]   sample_left,
   input wire logic [SAMPLE_W-1:0]   sample_right,
   input wire logic                  mute_left,
   input wire logic                  mute_right,
   input wire amute_pkg::stage_cfg_t stage_cfg
);
   wire take = ce && reg_req.en;
   wire wr53 = take && reg_req.wr && reg_req.addr == `OFS_STAGE_CTRL;
   wire wr54 = take && reg_req.wr && reg_req.addr == `OFS_LEVEL_TRIM;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_after_req:
      assert property (take |=> reg_ack) else $error("request not acked");
   a_ack_only_req:
      assert property (ce && !reg_req.en |=> !reg_ack) else $error("ack without request");
   a_stage_write:
      assert property (wr53 |=> stage_cfg.bandwidth == $past(reg_req.wdata[6:5])
         && stage_cfg.phase_same == $past(reg_req.wdata[0])) else $error("stage fields wrong");
   a_trim_write:
      assert property (wr54 |=> stage_cfg.level_trim == $past(reg_req.wdata[4:0])) else $error("trim wrong");
   a_left_release:
      assert property (ce && sample_valid && sample_left != 0 ##1 ce |=> !mute_left) else $error("left held");
   a_right_release:
      assert property (ce && sample_valid && sample_right != 0 ##1 ce |=> !mute_right) else $error("right held");
   a_left_rise_zero:
      assert property ($rose(mute_left) |-> $past(sample_left, 2) == 0) else $error("left muted on signal");
   a_right_rise_zero:
      assert property ($rose(mute_right) |-> $past(sample_right, 2) == 0) else $error("right muted on signal");
   a_ce_freeze:
      assert property (!ce |=> $stable(reg_ack) && $stable(stage_cfg)) else $error("moved while frozen");
endmodule : mute_chk
bind auto_mute_output_config mute_chk #(.SAMPLE_W(SAMPLE_W), .CNT_W(CNT_W)) i_chk (
   .clk(clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .sample_valid(sample_valid), .sample_left(sample_left),
   .sample_right(sample_right), .mute_left(mute_left), .mute_right(mute_right),
   .stage_cfg(stage_cfg)
);

// ### zero_run_detect.sv
/*
 one channel's zero-run counter and mute-condition state machine.
 assumes one sample strobe per sample period, synchronous to clk.
*/
`timescale 1ns/100ps
`include "amute_cfg.svh"
module zero_run_detect #(
   parameter int CNT_W = 20
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       sample_valid,
   input  wire logic       sample_zero,
   input  wire logic [2:0] hold_sel,
   output logic            hold_met
);
   localparam logic [CNT_W-1:0] HOLD_TABLE [8] = '{
      CNT_W'(`HOLD_SAMPLES(`HOLD_US_0)), CNT_W'(`HOLD_SAMPLES(`HOLD_US_1)),
      CNT_W'(`HOLD_SAMPLES(`HOLD_US_2)), CNT_W'(`HOLD_SAMPLES(`HOLD_US_3)),
      CNT_W'(`HOLD_SAMPLES(`HOLD_US_4)), CNT_W'(`HOLD_SAMPLES(`HOLD_US_5)),
      CNT_W'(`HOLD_SAMPLES(`HOLD_US_6)), CNT_W'(`HOLD_SAMPLES(`HOLD_US_7))};

   logic [CNT_W-1:0]     run_ff;
   logic [CNT_W-1:0]     nxt_run;
   amute_pkg::mute_state_t state_ff;
   amute_pkg::mute_state_t nxt_state;
   wire logic [CNT_W-1:0] limit   = HOLD_TABLE[hold_sel];
   wire logic             reached = (run_ff >= limit);

   // counter saturates at the limit so long silences never wrap
   always_comb begin
      nxt_run   = run_ff;
      nxt_state = state_ff;
      if (sample_valid) begin
         if (!sample_zero) begin
            nxt_run = '0; // R11
         end else if (!reached) begin
            nxt_run = run_ff + CNT_W'(1);
         end
      end
      case (state_ff)
         amute_pkg::ch_live: begin
            if (sample_valid && sample_zero && (nxt_run >= limit)) begin
               nxt_state = amute_pkg::ch_muted;
            end
         end
         amute_pkg::ch_muted: begin
            if (sample_valid && !sample_zero) begin
               nxt_state = amute_pkg::ch_live; // R11
            end
         end
         default: nxt_state = amute_pkg::ch_live;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_ff   <= '0;
         state_ff <= amute_pkg::ch_live;
      end else if (ce) begin
         run_ff   <= nxt_run;
         state_ff <= nxt_state;
      end
   end

   assign hold_met = (state_ff == amute_pkg::ch_muted);
endmodule : zero_run_detect
